// [shared/gpc_pkg.sv]
package gpc_pkg;
    localparam int          NPIN      = 6;
    localparam int          ADDR_W    = 12;
    localparam int          IDX_LSB   = 2;
    localparam int          IDX_W     = 8;
    // register indices; the byte address is four times the index
    localparam logic [7:0]  IDX_PIN5_3_CONFIG   = 8'hCB;
    localparam logic [7:0]  IDX_PIN5_4_CONFIG   = 8'hCC;
    localparam logic [7:0]  IDX_PIN6_0_CONFIG   = 8'hD0;
    localparam logic [7:0]  IDX_PIN6_1_CONFIG   = 8'hD1;
    localparam logic [7:0]  IDX_PIN6_2_CONFIG   = 8'hD2;
    localparam logic [7:0]  IDX_PIN6_3_CONFIG   = 8'hD3;
    localparam logic [7:0]  IDX_COMBINED_IRQ2   = 8'hEF;
    localparam logic [7:0]  IDX_GPIO_DATA       = 8'hF8;
    localparam logic [7:0]  IDX_PIN_LEVEL       = 8'hF9;
    localparam logic [7:0]  IDX_IRQ_STATUS      = 8'hFA;
    localparam logic [7:0]  IDX_IRQ_MASK        = 8'hFB;
    localparam logic [7:0]  PIN_IDX [NPIN] = '{IDX_PIN5_3_CONFIG, IDX_PIN5_4_CONFIG,
                                               IDX_PIN6_0_CONFIG, IDX_PIN6_1_CONFIG,
                                               IDX_PIN6_2_CONFIG, IDX_PIN6_3_CONFIG};
    // pin configuration fields
    localparam int          BIT_DIR   = 0;
    localparam int          BIT_POL   = 1;
    localparam int          FS_LSB    = 3;
    localparam int          FS_MSB    = 4;
    localparam int          BIT_GIE   = 5;
    localparam int          BIT_OD    = 7;
    localparam logic [7:0]  CFG_RST   = 8'h01;
    localparam logic [7:0]  CFG_WMASK = 8'hBB;
    localparam logic [1:0]  FN_ALT0   = 2'h0;
    localparam logic [1:0]  FN_IRQ    = 2'h1;
    localparam logic [1:0]  FN_GPIO   = 2'h2;
    localparam logic [1:0]  FN_ALT3   = 2'h3;
    // pins whose code 11 function drives the pin (system mgmt irq, led)
    localparam logic [5:0]  ALT3_OUT  = 6'h0C;
    // combined interrupt 2 fields
    localparam int          CI2_FLT   = 3;
    localparam int          CI2_MLSB  = 4;
    localparam int          CI2_MMSB  = 7;
    localparam logic [7:0]  CI2_RST   = 8'h00;
    localparam logic [7:0]  CI2_WMASK = 8'hF8;
    localparam logic [3:0]  MAP_OFF   = 4'h0;
    localparam logic [3:0]  DEB_CYCLES = 4'h8;
    // status bits
    localparam int          ST_EDGE3  = 0;
    localparam int          ST_EDGE4  = 1;
    localparam int          ST_GRP2   = 2;
    localparam int          ST_W      = 3;
endpackage : gpc_pkg

// [shared/gpc_sync_if.sv]
`timescale 1ns/1ps
interface gpc_sync_if;
    logic [5:0] raw;
    logic [5:0] clean;
    modport src (output raw, input clean);
    modport snk (input raw, output clean);
endinterface : gpc_sync_if

// [hw/gpc_pin_sync.sv]
`timescale 1ns/1ps
module gpc_pin_sync
    import gpc_pkg::*;
(
    input  logic         pclk,     // bus clock
    input  logic         presetn,  // async reset, low active
    input  logic         clk_en,   // freezes state while low
    gpc_sync_if.snk      s         // raw pins in, filtered levels out
);
    logic [NPIN-1:0] ff1_q;
    logic [NPIN-1:0] ff2_q;
    logic [NPIN-1:0] ff3_q;
    logic [NPIN-1:0] clean_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ff1_q <= '0;
            ff2_q <= '0;
            ff3_q <= '0;
        end
        else if (clk_en)
        begin
            ff1_q <= s.raw;
            ff2_q <= ff1_q;
            ff3_q <= ff2_q;
        end
    end

    // a level is taken only when the second and third stages agree
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            clean_q <= '0;
        else if (clk_en)
            clean_q <= (ff2_q & ff3_q) | (clean_q & (ff2_q | ff3_q));
    end

    assign s.clean = clean_q;
endmodule : gpc_pin_sync

// [hw/gpc_config.sv]
// Chosen here: register access over APB.
`timescale 1ns/1ps
// What this block does
// - In the gpio function, bit 0 of a pin register makes the pin an input when one and an output when zero.
// - Bit 1 inverts the pin's logical value when one and leaves it as is when zero.
// - Bit 7 selects open-drain drive when one and push-pull drive when zero.
// - Bit 5 admits the pin into combined interrupt 2; bits 2 and 6 are reserved.
// - Pin 5.3 function codes: rom chip select, irq11, gpio, either-edge interrupt 3.
// - Pin 5.4 function codes: rom output enable, irq12, gpio, either-edge interrupt 4.
// - Pin 6.0 function codes: parallel data 0, irq1, gpio, system mgmt interrupt out.
// - Pin 6.1 function codes: parallel data 1, irq3, gpio, led driver.
// - Pin 6.2 function codes: parallel data 2, irq4, gpio, ring indicator input.
// - Pin 6.3 function codes: parallel data 3, irq5, gpio; code 11 is not defined and leaves the pad undriven.
// - Combined irq 2 maps the group onto a host irq (0000 disables) with optional debounce.
module gpc_config
    import gpc_pkg::*;
(
    input  logic              pclk,                    // bus clock, 25 MHz
    input  logic              presetn,                 // async reset, low active
    input  logic              clk_en,                  // freezes all state while low
    input  logic              psel,                    // apb select
    input  logic              penable,                 // apb access phase
    input  logic              pwrite,                  // apb write
    input  logic [ADDR_W-1:0] paddr,                   // apb byte address
    input  logic [31:0]       pwdata,                  // apb write data
    output logic [31:0]       prdata,                  // apb read data
    output logic              pready,                  // apb ready
    output logic              pslverr,                 // apb error, unmapped address
    input  logic [5:0]        pin_in,                  // pad levels
    output logic [5:0]        pin_out,                 // pad drive values
    output logic [5:0]        pin_oe,                  // pad output enables
    input  logic              rom_chip_select_n,       // rom select from bios logic
    input  logic              rom_output_enable_n,     // rom read strobe from bios logic
    input  logic [3:0]        parallel_data_line_o,    // parallel data to pads
    input  logic [3:0]        parallel_data_line_oe,   // parallel data drive enables
    output logic [3:0]        parallel_data_line_i,    // parallel data from pads
    input  logic [5:0]        host_irq_src,            // irq11,12,1,3,4,5 sources
    input  logic              system_mgmt_interrupt_n, // system mgmt interrupt source
    input  logic              led_drive,               // led driver source
    output logic              ring_indicator_n,        // ring indicator from pad
    output logic              combined_irq2_req,       // grouped interrupt request
    output logic [3:0]        combined_irq2_line,      // host irq line for the group
    output logic              irq                      // unmasked status interrupt
);
    logic [7:0]      cfg_q [NPIN];
    logic [7:0]      ci2_q;
    logic [NPIN-1:0] data_q;
    logic [NPIN-1:0] lvl_prev_q;
    logic [ST_W-1:0] stat_q;
    logic [ST_W-1:0] mask_q;
    logic [3:0]      deb_cnt_q;
    logic            flt_q;
    logic [1:0]      fs [NPIN];
    logic [NPIN-1:0] lvl;
    logic [NPIN-1:0] drv_d;
    logic [NPIN-1:0] oe_d;
    logic [NPIN-1:0] gie;
    logic [NPIN-1:0] pin_hit;
    logic [31:0]     rd_d;
    logic [ST_W-1:0] set_d;
    logic [ST_W-1:0] clr_d;
    logic [IDX_W-1:0] idx;
    logic            aligned;
    logic            acc_start;
    logic            wr_go;
    logic            mapped;
    logic            grp_raw;
    logic            req_d;
    logic            filt_en;
    logic [3:0]      map;
    logic [31:0]     prdata_q;
    logic            pready_q;
    logic            pslverr_q;
    logic [5:0]      pin_out_q;
    logic [5:0]      pin_oe_q;
    logic [3:0]      pdl_i_q;
    logic            ring_q;
    logic            req_q;
    logic [3:0]      line_q;
    logic            irq_q;
    logic [5:0]      alt0_val;
    logic [5:0]      alt0_oe;
    logic [5:0]      alt3_val;

    gpc_sync_if sync_if ();
    assign sync_if.raw = pin_in;
    gpc_pin_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .s       (sync_if.snk)
    );

    // apb decode: the register index sits above the two byte-lane bits
    assign idx       = paddr[IDX_LSB+IDX_W-1:IDX_LSB];
    assign aligned   = (paddr[IDX_LSB-1:0] == '0) && (paddr[ADDR_W-1:IDX_LSB+IDX_W] == '0);
    assign acc_start = psel && penable && !pready_q;
    assign wr_go     = psel && penable && pready_q && pwrite && !pslverr_q;
    assign filt_en   = ci2_q[CI2_FLT];
    assign map       = ci2_q[CI2_MMSB:CI2_MLSB];

    assign alt0_val = {parallel_data_line_o, rom_output_enable_n, rom_chip_select_n};
    assign alt0_oe  = {parallel_data_line_oe, 2'h3};
    assign alt3_val = {2'h0, led_drive, system_mgmt_interrupt_n, 2'h0};

    genvar g;
    generate
        for (g = 0; g < NPIN; g++)
        begin : g_pin
            logic val;
            logic en;
            logic drv;
            assign fs[g]      = cfg_q[g][FS_MSB:FS_LSB];
            assign lvl[g]     = sync_if.clean[g] ^ cfg_q[g][BIT_POL];
            assign gie[g]     = cfg_q[g][BIT_GIE];
            assign pin_hit[g] = aligned && (idx == PIN_IDX[g]);

            // function select steers the pad between gpio and alternates
            always_comb
            begin
                case (fs[g])
                    FN_ALT0: begin val = alt0_val[g];     en = alt0_oe[g];   end
                    FN_IRQ:  begin val = host_irq_src[g]; en = 1'b1;         end
                    FN_GPIO: begin val = data_q[g];   en = !cfg_q[g][BIT_DIR]; end
                    FN_ALT3: begin val = alt3_val[g]; en = ALT3_OUT[g];      end
                    default: begin val = 1'b0;        en = 1'b0;             end
                endcase
            end

            assign drv = val ^ cfg_q[g][BIT_POL];
            // open drain only pulls low, so the enable follows the value
            assign drv_d[g] = cfg_q[g][BIT_OD] ? 1'b0 : drv;
            assign oe_d[g]  = cfg_q[g][BIT_OD] ? (en && !drv) : en;

            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    cfg_q[g] <= CFG_RST;
                else if (clk_en && wr_go && pin_hit[g])
                    cfg_q[g] <= pwdata[7:0] & CFG_WMASK;
            end
        end
    endgenerate

    always_comb
    begin
        rd_d   = '0;
        mapped = 1'b1;
        if (|pin_hit)
        begin
            for (int i = 0; i < NPIN; i++)
                if (pin_hit[i])
                    rd_d[7:0] = cfg_q[i];
        end
        else if (aligned && idx == IDX_COMBINED_IRQ2)
            rd_d[7:0] = ci2_q;
        else if (aligned && idx == IDX_GPIO_DATA)
            rd_d[NPIN-1:0] = data_q;
        else if (aligned && idx == IDX_PIN_LEVEL)
            rd_d[NPIN-1:0] = lvl;
        else if (aligned && idx == IDX_IRQ_STATUS)
            rd_d[ST_W-1:0] = stat_q;
        else if (aligned && idx == IDX_IRQ_MASK)
            rd_d[ST_W-1:0] = mask_q;
        else
            mapped = 1'b0;
    end

    // apb answer: ready one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end
        else if (clk_en)
        begin
            pready_q <= acc_start;
            if (acc_start)
            begin
                prdata_q  <= pwrite ? '0 : rd_d;
                pslverr_q <= !mapped;
            end
            else
                pslverr_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ci2_q  <= CI2_RST;
            data_q <= '0;
            mask_q <= '0;
        end
        else if (clk_en && wr_go && aligned)
        begin
            if (idx == IDX_COMBINED_IRQ2)
                ci2_q <= pwdata[7:0] & CI2_WMASK;
            if (idx == IDX_GPIO_DATA)
                data_q <= pwdata[NPIN-1:0];
            if (idx == IDX_IRQ_MASK)
                mask_q <= pwdata[ST_W-1:0];
        end
    end

    // group request with optional debounce
    assign grp_raw = |(lvl & gie);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            deb_cnt_q <= '0;
            flt_q     <= 1'b0;
        end
        else if (clk_en)
        begin
            if (!filt_en || grp_raw == flt_q)
            begin
                deb_cnt_q <= '0;
                flt_q     <= grp_raw;
            end
            else if (deb_cnt_q == DEB_CYCLES - 4'h1)
            begin
                deb_cnt_q <= '0;
                flt_q     <= grp_raw;
            end
            else
                deb_cnt_q <= deb_cnt_q + 4'h1;
        end
    end
    assign req_d = (map != MAP_OFF) && (filt_en ? flt_q : grp_raw);

    // sticky events; a set in the same cycle as its clear wins
    assign set_d[ST_EDGE3] = (fs[0] == FN_ALT3) && (lvl[0] != lvl_prev_q[0]);
    assign set_d[ST_EDGE4] = (fs[1] == FN_ALT3) && (lvl[1] != lvl_prev_q[1]);
    assign set_d[ST_GRP2]  = req_d && !req_q;
    assign clr_d = (wr_go && aligned && idx == IDX_IRQ_STATUS) ? pwdata[ST_W-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            stat_q     <= '0;
            lvl_prev_q <= '0;
            irq_q      <= 1'b0;
        end
        else if (clk_en)
        begin
            stat_q     <= (stat_q & ~clr_d) | set_d;
            lvl_prev_q <= lvl;
            irq_q      <= |(stat_q & mask_q);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_out_q <= '0;
            pin_oe_q  <= '0;
            pdl_i_q   <= '0;
            ring_q    <= 1'b1;
            req_q     <= 1'b0;
            line_q    <= MAP_OFF;
        end
        else if (clk_en)
        begin
            pin_out_q <= drv_d;
            pin_oe_q  <= oe_d;
            pdl_i_q   <= lvl[5:2];
            ring_q    <= (fs[4] == FN_ALT3) ? lvl[4] : 1'b1;
            req_q     <= req_d;
            line_q    <= map;
        end
    end

    assign prdata               = prdata_q;
    assign pready               = pready_q;
    assign pslverr              = pslverr_q;
    assign pin_out              = pin_out_q;
    assign pin_oe               = pin_oe_q;
    assign parallel_data_line_i = pdl_i_q;
    assign ring_indicator_n     = ring_q;
    assign combined_irq2_req    = req_q;
    assign combined_irq2_line   = line_q;
    assign irq                  = irq_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_gpio_dir_input: assert property (
        clk_en && fs[3] == FN_GPIO && cfg_q[3][BIT_DIR] |=> !pin_oe[3])
        else $error("gpio input pin is driven");
    a_gpio_polarity: assert property (
        clk_en && fs[3] == FN_GPIO && !cfg_q[3][BIT_DIR] && !cfg_q[3][BIT_OD]
        |=> pin_oe[3] && pin_out[3] == ($past(data_q[3]) ^ $past(cfg_q[3][BIT_POL])))
        else $error("gpio output value or polarity wrong");
    a_open_drain_high: assert property (
        clk_en && fs[3] == FN_GPIO && cfg_q[3][BIT_OD] && (data_q[3] ^ cfg_q[3][BIT_POL])
        |=> !pin_oe[3])
        else $error("open drain pin drives a high level");
    a_group_excluded: assert property (
        clk_en && gie == '0 && !filt_en |=> !combined_irq2_req)
        else $error("group request without enabled pins");
    a_rom_cs_route: assert property (
        clk_en && fs[0] == FN_ALT0 && !cfg_q[0][BIT_POL] && !cfg_q[0][BIT_OD]
        |=> pin_oe[0] && pin_out[0] == $past(rom_chip_select_n))
        else $error("rom select not routed to pin");
    a_edge_irq4: assert property (
        clk_en && fs[1] == FN_ALT3 && lvl[1] != lvl_prev_q[1] |=> stat_q[ST_EDGE4])
        else $error("edge on pin not recorded");
    a_smi_route: assert property (
        clk_en && fs[2] == FN_ALT3 && !cfg_q[2][BIT_POL] && !cfg_q[2][BIT_OD]
        |=> pin_oe[2] && pin_out[2] == $past(system_mgmt_interrupt_n))
        else $error("system mgmt interrupt not routed");
    a_ring_route: assert property (
        clk_en && fs[4] == FN_ALT3 |=> ring_indicator_n == $past(lvl[4]))
        else $error("ring indicator not taken from pin");
    a_irq5_route: assert property (
        clk_en && fs[5] == FN_IRQ && !cfg_q[5][BIT_OD]
        |=> pin_oe[5] && pin_out[5] == ($past(host_irq_src[5]) ^ $past(cfg_q[5][BIT_POL])))
        else $error("irq5 source not routed");
    a_map_disable: assert property (
        clk_en && map == MAP_OFF |=> !combined_irq2_req)
        else $error("disabled group mapping still requests");

    c_edge_event: cover property (stat_q[ST_EDGE3] && irq);
    c_group_req: cover property (filt_en && combined_irq2_req);
    c_bus_error: cover property (pready && pslverr);
endmodule : gpc_config

// [dv/gpc_board.sv]
`timescale 1ns/1ps
module gpc_board
(
    input  logic [5:0] pin_out, // pad drive values from the block
    input  logic [5:0] pin_oe,  // pad output enables from the block
    input  logic [5:0] ext_en,  // board drives the pad
    input  logic [5:0] ext_val, // board drive level
    output logic [5:0] pin_in   // resolved pad levels
);
    // pads carry pull-ups, so an undriven pad reads high
    always_comb
    begin
        for (int i = 0; i < 6; i++)
        begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
        end
    end
endmodule : gpc_board

// [dv/test_gpio_pin_config_group5_6.sv]
`timescale 1ns/1ps
module test_gpio_pin_config_group5_6
    import gpc_pkg::*;
;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic        pready, pslverr, rcs = 1, roe = 1, smi = 1, led = 0;
    logic [3:0]  pdo = '0, pdoe = '0, pdi, ci2_line;
    logic [5:0]  hirq = '0, ext_en = '0, ext_val = '0, pin_in, pin_out, pin_oe;
    logic        ring_n, ci2_req, irq;
    logic        clk_en = 1;
    int          n_mismatch = 0, total_checks = 0;

    always #20 pclk = ~pclk;

    gpc_config u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .rom_chip_select_n(rcs),
        .rom_output_enable_n(roe), .parallel_data_line_o(pdo),
        .parallel_data_line_oe(pdoe), .parallel_data_line_i(pdi), .host_irq_src(hirq),
        .system_mgmt_interrupt_n(smi), .led_drive(led), .ring_indicator_n(ring_n),
        .combined_irq2_req(ci2_req), .combined_irq2_line(ci2_line), .irq(irq));

    gpc_board u_board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_en(ext_en),
        .ext_val(ext_val), .pin_in(pin_in));

    task automatic close_out;
        if (n_mismatch == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge pclk);
    endtask : step

    // one apb transfer; waits for pready however long it takes
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        xfer(1'b1, idx, d, r, e);
    endtask : wr

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] m,
                          input logic [31:0] exp, input string what);
        logic [31:0] r;
        logic        e;
        xfer(1'b0, idx, 32'h0, r, e);
        chk(r & m, exp, what);
        chk({31'h0, e}, 32'h0, "slave error on mapped register");
    endtask : rd_chk

    initial
    begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        close_out();
    end

    initial
    begin
        logic [31:0] r;
        logic        e;
        step(2);
        presetn <= 1'b1;
        chk({ring_n, ci2_req, ci2_line, irq}, 32'h40, "reset outputs");
        for (int i = 0; i < NPIN; i++)
        begin
            rd_chk(PIN_IDX[i], 32'hFF, 32'h01, "config reset value");
            wr(PIN_IDX[i], 32'hFF);
            rd_chk(PIN_IDX[i], 32'hFF, 32'hBB, "reserved bits");
        end
        xfer(1'b0, 8'h00, 32'h0, r, e);
        chk({e, r[30:0]}, 32'h80000000, "unmapped read");
        // gpio output on pin 6.1: direction, polarity, driver type
        wr(IDX_GPIO_DATA, 32'h08);
        wr(PIN_IDX[3], 32'h10);
        step(3);
        chk({pin_oe[3], pin_out[3]}, 2'b11, "push-pull high");
        wr(PIN_IDX[3], 32'h12);
        step(3);
        chk({pin_oe[3], pin_out[3]}, 2'b10, "inverted output");
        wr(PIN_IDX[3], 32'h90);
        step(3);
        chk({pin_oe[3], pin_out[3]}, 2'b00, "open drain released");
        wr(IDX_GPIO_DATA, 32'h00);
        step(3);
        chk({pin_oe[3], pin_out[3]}, 2'b10, "open drain low");
        wr(PIN_IDX[3], 32'h11);
        step(3);
        chk(pin_oe[3], 1'b0, "input not driven");
        // gpio input on pin 6.2, plain and inverted, then ring indicator
        ext_en[4]  <= 1'b1;
        ext_val[4] <= 1'b0;
        wr(PIN_IDX[4], 32'h11);
        step(8);
        rd_chk(IDX_PIN_LEVEL, 32'h10, 32'h00, "input level");
        wr(PIN_IDX[4], 32'h13);
        step(8);
        rd_chk(IDX_PIN_LEVEL, 32'h10, 32'h10, "inverted input");
        chk(pdi[2], 1'b1, "parallel line in");
        wr(PIN_IDX[4], 32'h19);
        step(8);
        chk(ring_n, 1'b0, "ring low");
        ext_val[4] <= 1'b1;
        step(8);
        chk(ring_n, 1'b1, "ring high");
        // alternate output functions, each source at both levels
        for (int i = 0; i < NPIN; i++)
            for (int c = 0; c < 4; c++)
                if (c < 2 || i == 2 || i == 3)
                    for (int v = 0; v < 2; v++)
                    begin
                        {rcs, roe, smi, led} <= {4{v[0]}};
                        pdo  <= {4{v[0]}};
                        pdoe <= 4'hF;
                        hirq <= {6{v[0]}};
                        wr(IDX_GPIO_DATA, {26'h0, {6{v[0]}}});
                        wr(PIN_IDX[i], {27'h0, c[1:0], 3'h0});
                        step(3);
                        chk({pin_oe[i], pin_out[i]}, {1'b1, v[0]}, "alt drive");
                    end
        pdoe <= 4'h0;
        wr(PIN_IDX[2], 32'h00);
        step(3);
        chk(pin_oe[2], 1'b0, "parallel line released");
        // either-edge interrupts on pins 5.3 and 5.4, masked and unmasked
        for (int j = 0; j < 2; j++)
        begin
            ext_en[j]  <= 1'b1;
            ext_val[j] <= 1'b0;
            wr(PIN_IDX[j], 32'h19);
            step(8);
            wr(IDX_IRQ_STATUS, 32'h7);
            wr(IDX_IRQ_MASK, 32'h1 << j);
            ext_val[j] <= 1'b1;
            step(8);
            rd_chk(IDX_IRQ_STATUS, 32'h3, 32'h1 << j, "rising edge status");
            chk(irq, 1'b1, "irq raised");
            wr(IDX_IRQ_STATUS, 32'h1 << j);
            step(3);
            rd_chk(IDX_IRQ_STATUS, 32'h3, 32'h0, "status cleared");
            chk(irq, 1'b0, "irq cleared");
            wr(IDX_IRQ_MASK, 32'h0);
            ext_val[j] <= 1'b0;
            step(8);
            rd_chk(IDX_IRQ_STATUS, 32'h3, 32'h1 << j, "falling edge status");
            chk(irq, 1'b0, "masked irq");
            wr(IDX_IRQ_STATUS, 32'h7);
        end
        // combined interrupt 2: enable bit, mapping, debounce
        ext_en[5]  <= 1'b1;
        ext_val[5] <= 1'b0;
        wr(PIN_IDX[5], 32'h31);
        wr(IDX_COMBINED_IRQ2, 32'h57);
        rd_chk(IDX_COMBINED_IRQ2, 32'hFF, 32'h50, "combined irq register");
        chk(ci2_line, 4'h5, "mapped line");
        ext_val[5] <= 1'b1;
        step(8);
        chk(ci2_req, 1'b1, "group request");
        rd_chk(IDX_IRQ_STATUS, 32'h4, 32'h4, "group status");
        ext_val[5] <= 1'b0;
        step(8);
        chk(ci2_req, 1'b0, "group idle");
        wr(PIN_IDX[5], 32'h11);
        ext_val[5] <= 1'b1;
        step(8);
        chk(ci2_req, 1'b0, "pin excluded");
        wr(PIN_IDX[5], 32'h31);
        step(3);
        chk(ci2_req, 1'b1, "pin admitted");
        wr(IDX_COMBINED_IRQ2, 32'h00);
        step(3);
        chk(ci2_req, 1'b0, "mapping disabled");
        wr(IDX_COMBINED_IRQ2, 32'h58);
        step(30);
        chk(ci2_req, 1'b1, "filtered request");
        ext_val[5] <= 1'b0;
        step(5);
        chk(ci2_req, 1'b1, "filter holds");
        step(25);
        chk(ci2_req, 1'b0, "filter follows");
        // clock enable low freezes the whole input path
        clk_en     <= 1'b0;
        ext_val[5] <= 1'b1;
        step(40);
        chk(ci2_req, 1'b0, "frozen while disabled");
        clk_en <= 1'b1;
        step(30);
        chk(ci2_req, 1'b1, "resumes after enable");
        close_out();
    end
endmodule : test_gpio_pin_config_group5_6
